// ### src/clock_ratio_gen.sv
// Divider producing bus and peripheral rate enables from the core clock
module clock_ratio_gen #(
  parameter int RW = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Ratios from the clock ratio register
  input wire logic [RW-1:0] bus_ratio,
  input wire logic [RW-1:0] periph_ratio,
  // Rate enables
  output logic bus_clock_en,
  output logic periph_clock_en
);
  logic [RW-1:0] bus_cnt_q, bus_cnt_d;
  logic [RW-1:0] per_cnt_q, per_cnt_d;
  logic bus_en_q, bus_en_d, per_en_q, per_en_d;

  // A ratio of zero is treated like one, so the enable never dies
  always_comb begin
    bus_en_d = 1'b0;
    per_en_d = 1'b0;
    bus_cnt_d = bus_cnt_q + {{(RW-1){1'b0}}, 1'b1};
    per_cnt_d = per_cnt_q + {{(RW-1){1'b0}}, 1'b1};
    if (bus_cnt_d >= bus_ratio) begin
      bus_cnt_d = '0;
      bus_en_d = 1'b1;
    end
    if (per_cnt_d >= periph_ratio) begin
      per_cnt_d = '0;
      per_en_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_cnt_q <= '0;
      per_cnt_q <= '0;
      bus_en_q <= 1'b0;
      per_en_q <= 1'b0;
    end else begin
      bus_cnt_q <= bus_cnt_d;
      per_cnt_q <= per_cnt_d;
      bus_en_q <= bus_en_d;
      per_en_q <= per_en_d;
    end
  end

  assign bus_clock_en = bus_en_q;
  assign periph_clock_en = per_en_q;

endmodule : clock_ratio_gen

// ### src/dual_issue_hazard_control.sv
// Dual-issue pairing and hazard stall control for the core pipeline
module dual_issue_hazard_control #(
  parameter int LW = issue_pkg::LAT_W,
  parameter int RW = issue_pkg::REG_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Fetched pair and clock ratio write
  input wire logic fetch_valid,
  input wire issue_pkg::group_type first_group,
  input wire issue_pkg::op_type first_op,
  input wire logic first_double,
  input wire logic [LW-1:0] first_latency,
  input wire logic [LW-1:0] first_wb_latency,
  input wire logic [LW-1:0] first_issue_rate,
  input wire logic first_writes,
  input wire logic [RW-1:0] first_dest,
  input wire logic first_dest_fsc,
  input wire logic [RW-1:0] first_src_a,
  input wire logic [RW-1:0] first_src_b,
  input wire logic [LW-1:0] first_lock_time,
  input wire issue_pkg::group_type second_group,
  input wire issue_pkg::op_type second_op,
  input wire logic second_double,
  input wire logic second_writes,
  input wire logic [RW-1:0] second_dest,
  input wire logic second_dest_fsc,
  input wire logic second_reads_a,
  input wire logic second_reads_b,
  input wire logic [RW-1:0] second_src_a,
  input wire logic [RW-1:0] second_src_b,
  input wire logic second_needs_lock,
  input wire logic [issue_pkg::RATIO_W-1:0] ratio_bus_in,
  input wire logic [issue_pkg::RATIO_W-1:0] ratio_periph_in,
  input wire logic ratio_write,
  // Issue results and rate enables
  output logic fetch_ready,
  output logic issue_first,
  output logic issue_second,
  output logic issue_paired,
  output logic stall_busy,
  output logic [LW-1:0] stall_cycles,
  output logic bus_clock_en,
  output logic periph_clock_en
);
  import issue_pkg::*;

  typedef enum logic [1:0] {
    st_idle,
    st_wait,
    st_second
  } state_type;

  state_type state_q, state_d;
  logic [LW-1:0] wait_q, wait_d;
  logic [LW-1:0] lock_q, lock_d;
  logic [LW-1:0] stall_q, stall_d;
  logic iss1_q, iss1_d, iss2_q, iss2_d, pair_q, pair_d;
  logic [RATIO_W-1:0] bus_ratio_q, bus_ratio_d, per_ratio_q, per_ratio_d;
  logic can_pair;
  logic raw_hit, waw_hit, war_hit;
  logic [LW-1:0] flow_lat, raw_stall, waw_stall, war_stall, hazard;
  logic first_is_fp, second_dbl_kind, war_prod, war_cons;

  pair_check u_pair (
    .first_group(first_group),
    .second_group(second_group),
    .can_pair(can_pair)
  );

  clock_ratio_gen #(.RW(RATIO_W)) u_ratio (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .bus_ratio(bus_ratio_q),
    .periph_ratio(per_ratio_q),
    .bus_clock_en(bus_clock_en),
    .periph_clock_en(periph_clock_en)
  );

  // Hazard evaluation between the two fetched instructions
  always_comb begin
    first_is_fp = (first_group == float_unit_group);
    second_dbl_kind = second_double || second_op == op_inner_product ||
                      second_op == op_vector_matrix_transform;
    raw_hit = first_writes &&
              ((second_reads_a && second_src_a == first_dest) ||
               (second_reads_b && second_src_b == first_dest));
    flow_lat = first_latency;
    if (first_is_fp && second_op == op_float_store && flow_lat != '0) begin
      flow_lat = flow_lat - STORE_LAT_CUT;
    end
    if (first_op == op_load && second_src_a == first_dest &&
        (second_op == op_dynamic_arith_shift || second_op == op_dynamic_logic_shift)) begin
      flow_lat = flow_lat + SHIFT_LAT_ADD;
    end
    if (second_dbl_kind && flow_lat < DOUBLE_MIN_LAT) begin
      flow_lat = DOUBLE_MIN_LAT;
    end
    raw_stall = raw_hit ? flow_lat : '0;
    // Status register updates by both instructions never count as a shared destination
    waw_hit = first_is_fp && second_group == memory_access_group &&
              first_writes && second_writes && first_dest == second_dest &&
              !(first_dest_fsc && second_dest_fsc);
    waw_stall = '0;
    if (waw_hit) begin
      if (first_op == op_float_divide || first_op == op_float_square_root) begin
        waw_stall = (first_wb_latency > WAW_DIV_ADJ) ? first_wb_latency - WAW_DIV_ADJ : '0;
      end else begin
        waw_stall = (first_wb_latency > WAW_FE_ADJ) ? first_wb_latency - WAW_FE_ADJ : '0;
      end
    end
    war_prod = first_op == op_vector_matrix_transform ||
               (first_double && (first_op == op_float_add || first_op == op_float_subtract ||
                                 first_op == op_float_multiply));
    war_cons = second_op == op_float_move || second_op == op_load_float_zero ||
               second_op == op_load_float_one || second_op == op_float_absolute ||
               second_op == op_float_negate || second_op == op_float_from_comm;
    war_hit = war_prod && war_cons && second_writes &&
              (second_dest == first_src_a || second_dest == first_src_b);
    war_stall = '0;
    if (war_hit) begin
      war_stall = (first_op == op_vector_matrix_transform) ? WAR_TRANSFORM_STALL :
                  WAR_DOUBLE_STALL;
    end
    hazard = raw_stall;
    if (waw_stall > hazard) begin
      hazard = waw_stall;
    end
    if (war_stall > hazard) begin
      hazard = war_stall;
    end
  end

  // Issue sequencing; a pair with a nonzero hazard stall never issues together, keeping stages apart
  always_comb begin
    state_d = state_q;
    wait_d = (wait_q != '0) ? wait_q - 1'b1 : '0;
    lock_d = (lock_q != '0) ? lock_q - 1'b1 : '0;
    stall_d = stall_q;
    iss1_d = 1'b0;
    iss2_d = 1'b0;
    pair_d = 1'b0;
    bus_ratio_d = ratio_write ? ratio_bus_in : bus_ratio_q;
    per_ratio_d = ratio_write ? ratio_periph_in : per_ratio_q;
    case (state_q)
      st_idle: begin
        if (fetch_valid && wait_q == '0) begin
          iss1_d = 1'b1;
          lock_d = first_lock_time;
          if (can_pair && hazard == '0 && !second_needs_lock) begin
            iss2_d = 1'b1;
            pair_d = 1'b1;
            wait_d = first_issue_rate;
            stall_d = '0;
          end else begin
            wait_d = (hazard > first_issue_rate) ? hazard : first_issue_rate;
            stall_d = hazard;
            state_d = st_second;
          end
        end
      end
      st_second: begin
        // Second waits out issue rate, hazard and, when second_needs_lock is set, the held block lock
        if (wait_q <= 1 && (!second_needs_lock || lock_q <= 1)) begin
          iss2_d = 1'b1;
          stall_d = '0;
          state_d = st_idle;
        end
      end
      default: begin
        state_d = st_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= st_idle;
      wait_q <= '0;
      lock_q <= '0;
      stall_q <= '0;
      iss1_q <= 1'b0;
      iss2_q <= 1'b0;
      pair_q <= 1'b0;
      bus_ratio_q <= BUS_RATIO_RESET;
      per_ratio_q <= PERIPH_RATIO_RESET;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      lock_q <= lock_d;
      stall_q <= stall_d;
      iss1_q <= iss1_d;
      iss2_q <= iss2_d;
      pair_q <= pair_d;
      bus_ratio_q <= bus_ratio_d;
      per_ratio_q <= per_ratio_d;
    end
  end

  // Status flags registered so that every output leaves a flip-flop
  logic ready_q;
  logic busy_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      ready_q <= (state_d == st_idle) && (wait_d == '0);
      busy_q <= (state_d == st_second);
    end
  end

  assign fetch_ready = ready_q;
  assign issue_first = iss1_q;
  assign issue_second = iss2_q;
  assign issue_paired = pair_q;
  assign stall_busy = busy_q;
  assign stall_cycles = stall_q;

  // The group enum holds exactly six legal codes
  chk_group_legal: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fetch_valid |-> first_group <= serial_only_group)
    else $error("first group code out of range");

  chk_serial_alone: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (fetch_valid && state_q == st_idle && wait_q == '0 &&
     (first_group == serial_only_group || second_group == serial_only_group))
    |=> !issue_paired)
    else $error("serial only instruction was paired");

  chk_same_group: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (fetch_valid && state_q == st_idle && wait_q == '0 && first_group == second_group &&
     first_group != move_test_group) |=> !issue_paired)
    else $error("same group pair issued together");

  chk_add_jump: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (fetch_valid && state_q == st_idle && wait_q == '0 && first_group == integer_alu_group &&
     second_group == jump_class_group && hazard == '0 && !second_needs_lock)
    |=> issue_paired)
    else $error("add and jump not paired");

  chk_pair_both: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue_paired |-> issue_first && issue_second)
    else $error("pair flag without both issues");

  chk_raw_stall: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (fetch_valid && state_q == st_idle && wait_q == '0 && raw_hit && flow_lat > 4'h1 &&
     first_issue_rate <= flow_lat && !second_needs_lock)
    |=> issue_first && !issue_second ##1 !issue_second)
    else $error("dependent second issued early");

  chk_war_five: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == st_idle && fetch_valid && wait_q == '0 && war_hit && !raw_hit &&
     !waw_hit && first_op == op_vector_matrix_transform) |=> stall_cycles == 4'h5)
    else $error("transform anti-flow stall not five");

  chk_fsc_free: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (first_dest_fsc && second_dest_fsc) |-> !waw_hit)
    else $error("status register caused output stall");

  chk_in_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (issue_first && !issue_second) |-> ##[1:40] issue_second)
    else $error("second instruction never issued");

  cov_paired: cover property (@(posedge ref_clk) disable iff (!rst_n) issue_paired);
  cov_split: cover property (@(posedge ref_clk) disable iff (!rst_n)
    issue_first && !issue_second);
  cov_waw: cover property (@(posedge ref_clk) disable iff (!rst_n) waw_hit && fetch_valid);
  cov_lock: cover property (@(posedge ref_clk) disable iff (!rst_n)
    stall_busy && second_needs_lock && lock_q != '0);

endmodule : dual_issue_hazard_control

// ### src/issue_pkg.sv
// Package with instruction groups, operation kinds and latency constants for the issue control
package issue_pkg;

  typedef enum logic [2:0] {
    move_test_group,
    integer_alu_group,
    jump_class_group,
    memory_access_group,
    float_unit_group,
    serial_only_group
  } group_type;

  typedef enum logic [4:0] {
    op_other,
    op_int_add,
    op_unconditional_jump,
    op_load,
    op_store,
    op_float_store,
    op_dynamic_arith_shift,
    op_dynamic_logic_shift,
    op_float_divide,
    op_float_square_root,
    op_vector_matrix_transform,
    op_inner_product,
    op_float_add,
    op_float_subtract,
    op_float_multiply,
    op_float_move,
    op_load_float_zero,
    op_load_float_one,
    op_float_absolute,
    op_float_negate,
    op_float_from_comm
  } op_type;

  localparam int LAT_W = 4;
  localparam int REG_W = 5;
  localparam int RATIO_W = 4;

  localparam logic [LAT_W-1:0] WAW_DIV_ADJ = 4'h1;
  localparam logic [LAT_W-1:0] WAW_FE_ADJ = 4'h2;
  localparam logic [LAT_W-1:0] WAR_TRANSFORM_STALL = 4'h5;
  localparam logic [LAT_W-1:0] WAR_DOUBLE_STALL = 4'h2;
  localparam logic [LAT_W-1:0] STORE_LAT_CUT = 4'h1;
  localparam logic [LAT_W-1:0] SHIFT_LAT_ADD = 4'h1;
  localparam logic [LAT_W-1:0] DOUBLE_MIN_LAT = 4'h2;

  localparam logic [RATIO_W-1:0] BUS_RATIO_RESET = 4'h2;
  localparam logic [RATIO_W-1:0] PERIPH_RATIO_RESET = 4'h4;

endpackage : issue_pkg

// ### src/pair_check.sv
// Pairing decision for two fetched instructions by functional group
module pair_check (
  // Candidate groups
  input wire issue_pkg::group_type first_group,
  input wire issue_pkg::group_type second_group,
  // Decision
  output logic can_pair
);
  import issue_pkg::*;

  always_comb begin
    can_pair = 1'b1;
    if (first_group == serial_only_group || second_group == serial_only_group) begin
      can_pair = 1'b0;
    end else if (first_group == second_group && first_group != move_test_group) begin
      can_pair = 1'b0;
    end
    // Add with jump falls into the differing-group case
  end

endmodule : pair_check

// ### verif/tb.sv
// Self-checking bench for the dual-issue pairing and hazard stall control
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import issue_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, fetch_valid = 1'b0, ratio_write = 1'b0;
  group_type first_group = move_test_group, second_group = move_test_group;
  op_type first_op = op_other, second_op = op_other;
  logic first_double, second_double, first_writes, second_writes, first_dest_fsc;
  logic second_dest_fsc, second_reads_a, second_reads_b, second_needs_lock;
  logic [3:0] first_latency, first_wb_latency, first_issue_rate, first_lock_time;
  logic [4:0] first_dest, first_src_a, first_src_b, second_dest, second_src_a, second_src_b;
  logic [3:0] ratio_bus_in = 4'h0, ratio_periph_in = 4'h0, stall_cycles;
  logic fetch_ready, issue_first, issue_second, issue_paired, stall_busy;
  logic bus_clock_en, periph_clock_en;
  int failures = 0, checked = 0, seed = 32'h4dc5531e, g;
  logic pd;
  logic [3:0] sc;

  dual_issue_hazard_control dut (.ref_clk, .rst_n, .fetch_valid, .first_group, .first_op,
    .first_double, .first_latency, .first_wb_latency, .first_issue_rate, .first_writes,
    .first_dest, .first_dest_fsc, .first_src_a, .first_src_b, .first_lock_time, .second_group,
    .second_op, .second_double, .second_writes, .second_dest, .second_dest_fsc,
    .second_reads_a, .second_reads_b, .second_src_a, .second_src_b, .second_needs_lock,
    .ratio_bus_in, .ratio_periph_in, .ratio_write, .fetch_ready, .issue_first, .issue_second,
    .issue_paired, .stall_busy, .stall_cycles, .bus_clock_en, .periph_clock_en);

  always #5 ref_clk = ~ref_clk;

  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  // Hazard-free defaults: distinct registers, nothing read, nothing locked
  task automatic clear();
    {first_double, second_double, first_dest_fsc, second_dest_fsc} = 4'h0;
    {second_writes, second_reads_a, second_reads_b, second_needs_lock} = 4'h0;
    first_writes = 1'b1;
    first_op = op_other;
    second_op = op_other;
    {first_latency, first_wb_latency, first_issue_rate, first_lock_time} = 16'h1110;
    {first_dest, first_src_a, first_src_b} = {5'h01, 5'h02, 5'h03};
    {second_dest, second_src_a, second_src_b} = {5'h06, 5'h04, 5'h05};
  endtask : clear

  function automatic logic exp_pair(group_type a, group_type b);
    if (a == serial_only_group || b == serial_only_group) return 1'b0;
    return a != b || a == move_test_group;
  endfunction : exp_pair

  // Worst of the flow, output and anti-flow waits for the presented pair
  function automatic int exp_stall();
    int raw = 0, waw = 0, war = 0, lat = first_latency;
    if (first_group == float_unit_group && second_op == op_float_store) lat--;
    if (first_op == op_load && second_op inside {op_dynamic_arith_shift,
        op_dynamic_logic_shift}) lat++;
    if (lat < 2 && (second_double || second_op inside {op_inner_product,
        op_vector_matrix_transform})) lat = 2;
    if (first_writes && ((second_reads_a && second_src_a == first_dest) ||
        (second_reads_b && second_src_b == first_dest))) raw = lat;
    if (first_writes && second_writes && first_dest == second_dest && !second_dest_fsc &&
        first_group == float_unit_group && second_group == memory_access_group)
      waw = first_wb_latency - (first_op inside {op_float_divide,
        op_float_square_root} ? 1 : 2);
    if (second_writes && (second_dest == first_src_a || second_dest == first_src_b) &&
        second_op inside {op_float_move, op_load_float_zero, op_load_float_one,
        op_float_absolute, op_float_negate, op_float_from_comm}) begin
      if (first_op == op_vector_matrix_transform) war = 5;
      else if (first_double && first_op inside {op_float_add, op_float_subtract,
          op_float_multiply}) war = 2;
    end
    if (waw > raw) raw = waw;
    return war > raw ? war : raw;
  endfunction : exp_stall

  // Presents the pair, holds it until the second issues, then waits for idle
  task automatic run(output logic pd, output logic [3:0] sc, output int gap);
    int n = 0, t1 = -1;
    {pd, sc} = 5'h00;
    gap = -1;
    fetch_valid = 1'b1;
    while (gap < 0 && n < 60) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (issue_first === 1'b1) begin
        t1 = n;
        pd = issue_paired;
      end
      if (stall_busy === 1'b1) sc = stall_cycles;
      if (issue_second === 1'b1) begin
        chk(t1 >= 0, "second ahead of first");
        gap = n - t1;
      end
    end
    fetch_valid = 1'b0;
    chk(gap >= 0, "second never issued");
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (fetch_ready !== 1'b1 && n < 40);
    chk(fetch_ready === 1'b1, "not ready after issue");
  endtask : run

  // Mode 0 flow, 1 output, 2 anti-flow, 3 output on the status register only
  task automatic hz(input op_type o1, input group_type g1, input logic d1, input logic [3:0] lt,
      input op_type o2, input group_type g2, input logic d2, input int mode);
    int e, gap;
    clear();
    {first_op, first_group, first_double, first_latency} = {o1, g1, d1, lt};
    {second_op, second_group, second_double} = {o2, g2, d2};
    first_wb_latency = lt + 4'h1;
    second_reads_a = (mode == 0);
    second_src_a = (mode == 0) ? first_dest : 5'h04;
    second_writes = (mode != 0);
    second_dest = (mode == 2) ? first_src_a : (mode == 0) ? 5'h06 : first_dest;
    {first_dest_fsc, second_dest_fsc} = {2{mode == 3}};
    e = exp_stall();
    run(pd, sc, gap);
    if (e > 0) chk(sc === 4'(e), "wrong stall count");
    chk(gap >= e, "second issued too early");
    chk(pd === (e == 0 && exp_pair(g1, g2)), "wrong pairing under hazard");
  endtask : hz

  task automatic gap_of(input logic which, output int g);
    int n = 0;
    while ((which ? periph_clock_en : bus_clock_en) !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    g = 0;
    do begin
      @(posedge ref_clk);
      #1;
      g++;
    end while ((which ? periph_clock_en : bus_clock_en) !== 1'b1 && g < 40);
  endtask : gap_of

  initial begin
    #200us;
    failures++;
    end_sim();
  end

  initial begin
    clear();
    #25;
    chk({issue_first, issue_second, issue_paired, stall_busy} === 4'h0, "busy in reset");
    #16;
    rst_n = 1'b1;
    @(posedge ref_clk);
    #1;
    gap_of(1'b0, g);
    chk(g == BUS_RATIO_RESET, "bus rate after reset");
    gap_of(1'b1, g);
    chk(g == PERIPH_RATIO_RESET, "peripheral rate after reset");
    {ratio_bus_in, ratio_periph_in, ratio_write} = {4'h3, 4'h5, 1'b1};
    @(posedge ref_clk);
    #1;
    ratio_write = 1'b0;
    gap_of(1'b0, g);
    gap_of(1'b0, g);
    chk(g == 3, "bus rate after write");
    gap_of(1'b1, g);
    gap_of(1'b1, g);
    chk(g == 5, "peripheral rate after write");
    clear();
    {first_group, first_op, second_group, second_op} =
      {integer_alu_group, op_int_add, jump_class_group, op_unconditional_jump};
    run(pd, sc, g);
    chk(pd === 1'b1 && g == 0, "add with jump not paired");
    repeat (60) begin
      clear();
      first_group = group_type'(3'($unsigned($random(seed)) % 6));
      second_group = group_type'(3'($unsigned($random(seed)) % 6));
      first_issue_rate = 4'(1 + $unsigned($random(seed)) % 3);
      run(pd, sc, g);
      chk(pd === exp_pair(first_group, second_group), "group pairing");
      if (!exp_pair(first_group, second_group))
        chk(g >= first_issue_rate, "split pair too close");
    end
    clear();
    {first_group, second_group, first_issue_rate} = {serial_only_group, serial_only_group, 4'h4};
    run(pd, sc, g);
    chk(pd === 1'b0 && g >= 4, "issue rate ignored");
    clear();
    {first_lock_time, second_needs_lock} = {4'h3, 1'b1};
    run(pd, sc, g);
    chk(pd === 1'b0 && g >= 3, "locked block used early");
    hz(op_float_add, float_unit_group, 0, 4'h4, op_int_add, integer_alu_group, 0, 0);
    hz(op_float_multiply, float_unit_group, 0, 4'h4, op_float_store, memory_access_group, 0, 0);
    hz(op_load, memory_access_group, 0, 4'h2, op_dynamic_arith_shift, integer_alu_group, 0, 0);
    hz(op_load, memory_access_group, 0, 4'h2, op_dynamic_logic_shift, integer_alu_group, 0, 0);
    hz(op_int_add, integer_alu_group, 0, 4'h1, op_float_add, float_unit_group, 1, 0);
    hz(op_int_add, integer_alu_group, 0, 4'h1, op_inner_product, float_unit_group, 0, 0);
    hz(op_float_divide, float_unit_group, 0, 4'ha, op_load, memory_access_group, 0, 1);
    hz(op_float_square_root, float_unit_group, 0, 4'h9, op_load, memory_access_group, 0, 1);
    hz(op_float_multiply, float_unit_group, 0, 4'h5, op_load, memory_access_group, 0, 1);
    hz(op_float_divide, float_unit_group, 0, 4'ha, op_float_move, memory_access_group, 0, 3);
    hz(op_vector_matrix_transform, float_unit_group, 0, 4'h5, op_float_move,
       memory_access_group, 0, 2);
    hz(op_float_add, float_unit_group, 1, 4'h6, op_float_negate, memory_access_group, 0, 2);
    hz(op_float_subtract, float_unit_group, 1, 4'h6, op_load, memory_access_group, 0, 2);
    end_sim();
  end
endmodule : tb
